// ### inc/wkt_pkg.sv
package wkt_pkg;
   // ==================================
   // Register offsets (byte addresses)
   localparam logic [6:0] OFS_CNT_LO = 7'h00;
   localparam logic [6:0] OFS_CNT_HI = 7'h04;
   localparam logic [6:0] OFS_CTRL = 7'h08;
   localparam logic [6:0] OFS_RUN = 7'h0C;
   localparam logic [6:0] OFS_CMPA_LO = 7'h10;
   localparam logic [6:0] OFS_CMPA_HI = 7'h14;
   localparam logic [6:0] OFS_CMPB_LO = 7'h18;
   localparam logic [6:0] OFS_CMPB_HI = 7'h1C;
   localparam logic [6:0] OFS_CMPC_LO = 7'h20;
   localparam logic [6:0] OFS_CMPC_HI = 7'h24;
   localparam logic [6:0] OFS_IEN = 7'h28;
   localparam logic [6:0] OFS_STAT = 7'h2C;
   localparam logic [6:0] OFS_CLR = 7'h30;
   localparam logic [6:0] OFS_CAP_LO = 7'h3C;
   localparam logic [6:0] OFS_CAP_HI = 7'h40;
   // ==================================
   // Values after reset, control write mask and full scale
   localparam logic [15:0] RST_CTRL = 16'h0010;
   localparam logic [31:0] RST_CMP_A = 32'h00001FFF;
   localparam logic [31:0] RST_CMP_B = 32'h00002FFF;
   localparam logic [31:0] RST_CMP_C = 32'h00003FFF;
   localparam logic [3:0] RST_IEN = 4'h0;
   localparam logic [15:0] CTRL_WMASK = 16'h0FFF;
   localparam logic [31:0] FULL_SCALE = 32'hFFFFFFFF;
   // ==================================
   // Control field positions
   localparam int unsigned CB_PRE = 0;
   localparam int unsigned CB_DIR = 2;
   localparam int unsigned CB_FRZ = 3;
   localparam int unsigned CB_FREE = 4;
   localparam int unsigned CB_SRC = 5;
   localparam int unsigned CB_CAPEN = 7;
   localparam int unsigned CB_EVSEL = 8;
   // ==================================
   // Counts and dividers
   localparam int unsigned N_EVENTS = 13;
   localparam logic [15:0] DIV_ONE = 16'h0001;
   localparam logic [15:0] DIV_FAST = 16'h0004;
   localparam logic [15:0] DIV_16 = 16'h0010;
   localparam logic [15:0] DIV_256 = 16'h0100;
   localparam int unsigned PRE_MAX = 32768;
   localparam logic [1:0] SYNC_EDGES = 2'h2;
   // Tick source codes
   typedef enum logic [1:0] {
      WKT_SRC_PCLK = 2'h0,
      WKT_SRC_SLOW = 2'h1,
      WKT_SRC_USER = 2'h2,
      WKT_SRC_EXT = 2'h3
   } wkt_src_e;
   // Prescaler codes
   typedef enum logic [1:0] {
      WKT_DIV_1 = 2'h0,
      WKT_DIV_16 = 2'h1,
      WKT_DIV_256 = 2'h2,
      WKT_DIV_MAX = 2'h3
   } wkt_div_e;
endpackage

// ### inc/wkt_tick_if.sv
`timescale 1ns/1ps
// Tick path between the timer core and its prescaler
interface wkt_tick_if;
   logic src_tick; // One-cycle pulse per source edge
   logic four_x; // Fast source, divide-by-one becomes four
   logic [1:0] div_sel; // Prescaler code
   logic run; // Low holds the prescaler cleared
   logic tick; // One-cycle counter advance
   modport ctl (output src_tick, four_x, div_sel, run, input tick);
   modport pre (input src_tick, four_x, div_sel, run, output tick);
endinterface

// ### rtl/wkt_sync_edge.sv
`timescale 1ns/1ps
// Two-flop synchroniser with rising-edge detect per bit
module wkt_sync_edge #(
   parameter int unsigned W = 16
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [W-1:0] din,
   output logic [W-1:0] rise
);
   // ==================================
   // State
   typedef struct packed {
      logic [W-1:0] s1; // Metastable stage, read only by s2
      logic [W-1:0] s2; // Safe level
      logic [W-1:0] s3; // Previous safe level
   } wkt_sync_s;
   wkt_sync_s st_r, st_nxt;

   // Shift chain
   always_comb begin
      st_nxt.s1 = din;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
   end

   // Register with freeze
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign rise = st_r.s2 & ~st_r.s3;
endmodule

// ### rtl/wkt_prescaler.sv
`timescale 1ns/1ps
// Divides source ticks into counter ticks
module wkt_prescaler #(
   parameter int unsigned MAX_DIV = wkt_pkg::PRE_MAX
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   wkt_tick_if.pre tk
);
   // ==================================
   // State
   typedef struct packed {
      logic [15:0] cnt; // Source ticks seen
      logic tick; // Registered advance pulse
   } wkt_pre_s;
   wkt_pre_s st_r, st_nxt;
   logic [15:0] lim; // Division ratio

   // Ratio decode
   always_comb begin
      unique case (wkt_pkg::wkt_div_e'(tk.div_sel))
         wkt_pkg::WKT_DIV_1: lim = tk.four_x ? wkt_pkg::DIV_FAST : wkt_pkg::DIV_ONE;
         wkt_pkg::WKT_DIV_16: lim = wkt_pkg::DIV_16;
         wkt_pkg::WKT_DIV_256: lim = wkt_pkg::DIV_256;
         wkt_pkg::WKT_DIV_MAX: lim = 16'(MAX_DIV);
      endcase
   end

   // Count; >= guards against a ratio shrunk mid-count
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (!tk.run) begin
         st_nxt.cnt = 16'h0000;
      end else if (tk.src_tick) begin
         if (st_r.cnt >= lim - 16'h0001) begin
            st_nxt.cnt = 16'h0000;
            st_nxt.tick = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
         end
      end
   end

   // Register with freeze
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign tk.tick = st_r.tick;
endmodule

// ### rtl/wkt_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Racing match latched, raises line on re-enable
// - Three compare fields; field C wins
// - Periodic: C match reloads start value
// - Free-run: counter wraps at full scale
// - Field enable gates match, flag, pulse
// - Count read as two 16-bit halves
// - Control 11:8 selects capture source
// - Control bit 7 enables capture
// - Control 6:5 selects tick source
// - Freeze: low read latches high half
// - Control bit 2 sets count direction
// - Control 1:0 selects prescaler ratio
// - Run bit low holds reset state
// - Sync flag set on run change, auto-clears
// - Match flags clear on status read
// - Capture edge records count, sets flag
// - Clear register ones clear flags
module wkt_top #(
   parameter int unsigned PRE_DIV_MAX = wkt_pkg::PRE_MAX
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic slow_oscillator,
   input wire logic user_clock,
   input wire logic external_tick_input,
   input wire logic [12:0] event_lines,
   output logic wake_pulse,
   output logic irq
);
   // ==================================
   // State
   typedef struct packed {
      logic [15:0] ctrl; // Control register
      logic run_en; // Run bit as written
      logic run_eff; // Run bit after sync
      logic en_sync; // Run change in flight
      logic [1:0] sync_cnt; // Slow edges seen
      logic [31:0] cmp_a; // Field A
      logic [31:0] cmp_b; // Field B
      logic [31:0] cmp_c; // Field C
      logic [3:0] ien; // Match and rollover enables
      logic [4:0] flags; // Capture, roll, C, B, A
      logic [31:0] count; // Live counter
      logic [15:0] hold_hi; // Frozen upper half
      logic frozen; // Upper half held
      logic [31:0] cap; // Captured count
      logic [3:0] hit; // Matches from last tick
      logic wake; // Wake pulse
      logic irq; // Interrupt line
      logic wr_pend; // Write data phase
      logic rd_pend; // Read wait cycle
      logic [6:0] addr; // Latched offset
      logic [15:0] rdata; // Read data
   } wkt_top_s;
   wkt_top_s st_r, st_nxt;

   localparam wkt_top_s RST_ST = '{
      ctrl: wkt_pkg::RST_CTRL,
      cmp_a: wkt_pkg::RST_CMP_A,
      cmp_b: wkt_pkg::RST_CMP_B,
      cmp_c: wkt_pkg::RST_CMP_C,
      ien: wkt_pkg::RST_IEN,
      default: '0
   };

   // ==================================
   // Pin synchronisers and prescaler
   logic [15:0] rise; // Edges: events, ext, user, slow
   logic slow_rise; // Slow oscillator edge
   logic [15:0] ev_pad; // Events, reserved codes zero
   wkt_tick_if tk ();

   wkt_sync_edge #(
      .W(16)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .ce(ce),
      .din({event_lines, external_tick_input, user_clock, slow_oscillator}),
      .rise(rise)
   );

   wkt_prescaler #(
      .MAX_DIV(PRE_DIV_MAX)
   ) u_pre (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .ce(ce),
      .tk(tk)
   );

   assign slow_rise = rise[0];
   assign ev_pad = {3'b000, rise[15:3]};

   // Tick source select; peripheral clock is ref_clk itself
   always_comb begin
      tk.four_x = 1'b0;
      unique case (wkt_pkg::wkt_src_e'(st_r.ctrl[wkt_pkg::CB_SRC +: 2]))
         wkt_pkg::WKT_SRC_PCLK: begin
            tk.src_tick = 1'b1;
            tk.four_x = 1'b1;
         end
         wkt_pkg::WKT_SRC_SLOW: tk.src_tick = slow_rise;
         wkt_pkg::WKT_SRC_USER: begin
            tk.src_tick = rise[1];
            tk.four_x = 1'b1;
         end
         wkt_pkg::WKT_SRC_EXT: tk.src_tick = rise[2];
      endcase
   end
   assign tk.div_sel = st_r.ctrl[wkt_pkg::CB_PRE +: 2];
   assign tk.run = st_r.run_eff;

   // ==================================
   // Counter helpers
   logic free; // Free-running mode
   logic dir; // High counts down
   logic [31:0] start; // Reset-state value
   logic [3:0] m; // Enabled matches on current count
   logic acc; // Bus address phase taken
   logic [15:0] wd; // Write data low half
   logic cap_ev; // Capture edge this cycle

   assign free = st_r.ctrl[wkt_pkg::CB_FREE];
   assign dir = st_r.ctrl[wkt_pkg::CB_DIR];
   assign start = dir ? wkt_pkg::FULL_SCALE : 32'h00000000;
   // Disabled fields never match at all
   assign m[0] = st_r.ien[0] && st_r.count == st_r.cmp_a;
   assign m[1] = st_r.ien[1] && st_r.count == st_r.cmp_b;
   assign m[2] = st_r.ien[2] && st_r.count == st_r.cmp_c;
   assign m[3] = st_r.ien[3] && free && st_r.count == ~start;
   assign acc = hsel && htrans[1] && hready;
   assign wd = hwdata[15:0];
   assign cap_ev = st_r.ctrl[wkt_pkg::CB_CAPEN]
      && ev_pad[st_r.ctrl[wkt_pkg::CB_EVSEL +: 4]];

   // ==================================
   // Next-state logic
   always_comb begin
      st_nxt = st_r;
      st_nxt.hit = 4'h0;
      // Bus address phase; only whole words exist
      st_nxt.wr_pend = acc && hwrite;
      st_nxt.rd_pend = acc && !hwrite;
      if (acc) begin
         st_nxt.addr = {haddr[6:2], 2'b00};
      end
      // Run change crosses on slow oscillator edges
      if (st_r.en_sync && slow_rise) begin
         if (st_r.sync_cnt == wkt_pkg::SYNC_EDGES - 2'h1) begin
            st_nxt.run_eff = st_r.run_en;
            st_nxt.en_sync = 1'b0;
            st_nxt.sync_cnt = 2'h0;
         end else begin
            st_nxt.sync_cnt = st_r.sync_cnt + 2'h1;
         end
      end
      // Counter
      if (!st_r.run_eff) begin
         st_nxt.count = start;
      end else if (tk.tick) begin
         st_nxt.hit = m;
         if (!free && m[2]) begin
            st_nxt.count = start;
         end else if (dir) begin
            st_nxt.count = st_r.count - 32'h00000001;
         end else begin
            st_nxt.count = st_r.count + 32'h00000001;
         end
      end
      // Read data, one wait cycle so a prior write lands first
      if (st_r.rd_pend) begin
         st_nxt.rdata = 16'h0000;
         case (st_r.addr)
            wkt_pkg::OFS_CNT_LO: begin
               st_nxt.rdata = st_r.count[15:0];
               if (st_r.ctrl[wkt_pkg::CB_FRZ]) begin
                  st_nxt.hold_hi = st_r.count[31:16];
                  st_nxt.frozen = 1'b1;
               end
            end
            wkt_pkg::OFS_CNT_HI: begin
               st_nxt.rdata = st_r.frozen ? st_r.hold_hi : st_r.count[31:16];
               st_nxt.frozen = 1'b0;
            end
            wkt_pkg::OFS_CTRL: st_nxt.rdata = st_r.ctrl;
            wkt_pkg::OFS_RUN: st_nxt.rdata = {15'h0000, st_r.run_en};
            wkt_pkg::OFS_CMPA_LO: st_nxt.rdata = st_r.cmp_a[15:0];
            wkt_pkg::OFS_CMPA_HI: st_nxt.rdata = st_r.cmp_a[31:16];
            wkt_pkg::OFS_CMPB_LO: st_nxt.rdata = st_r.cmp_b[15:0];
            wkt_pkg::OFS_CMPB_HI: st_nxt.rdata = st_r.cmp_b[31:16];
            wkt_pkg::OFS_CMPC_LO: st_nxt.rdata = st_r.cmp_c[15:0];
            wkt_pkg::OFS_CMPC_HI: st_nxt.rdata = st_r.cmp_c[31:16];
            wkt_pkg::OFS_IEN: st_nxt.rdata = {12'h000, st_r.ien};
            wkt_pkg::OFS_STAT: begin
               st_nxt.rdata = {7'h00, st_r.en_sync, st_r.frozen, |st_r.flags,
                  1'b0, st_r.flags};
               st_nxt.flags[2:0] = 3'b000;
            end
            wkt_pkg::OFS_CAP_LO: st_nxt.rdata = st_r.cap[15:0];
            wkt_pkg::OFS_CAP_HI: begin
               st_nxt.rdata = st_r.cap[31:16];
               st_nxt.flags[4] = 1'b0;
            end
            // Unmapped and write-only offsets read zero
            default: st_nxt.rdata = 16'h0000;
         endcase
      end
      // Write data phase; software owns the safe-update order
      if (st_r.wr_pend) begin
         case (st_r.addr)
            wkt_pkg::OFS_CTRL: st_nxt.ctrl = wd & wkt_pkg::CTRL_WMASK;
            wkt_pkg::OFS_RUN: begin
               st_nxt.run_en = wd[0];
               if (wd[0] != st_r.run_en) begin
                  st_nxt.en_sync = 1'b1;
                  st_nxt.sync_cnt = 2'h0;
               end
            end
            wkt_pkg::OFS_CMPA_LO: st_nxt.cmp_a[15:0] = wd;
            wkt_pkg::OFS_CMPA_HI: st_nxt.cmp_a[31:16] = wd;
            wkt_pkg::OFS_CMPB_LO: st_nxt.cmp_b[15:0] = wd;
            wkt_pkg::OFS_CMPB_HI: st_nxt.cmp_b[31:16] = wd;
            wkt_pkg::OFS_CMPC_LO: st_nxt.cmp_c[15:0] = wd;
            wkt_pkg::OFS_CMPC_HI: st_nxt.cmp_c[31:16] = wd;
            wkt_pkg::OFS_IEN: st_nxt.ien = wd[3:0];
            wkt_pkg::OFS_CLR: st_nxt.flags = st_nxt.flags & ~wd[4:0];
            // Read-only and unmapped offsets ignore writes
            default: st_nxt.ctrl = st_nxt.ctrl;
         endcase
      end
      // Hardware sets after all clears, so a set is never lost
      st_nxt.flags[3:0] = st_nxt.flags[3:0] | st_r.hit;
      if (cap_ev) begin
         st_nxt.cap = st_r.count;
         st_nxt.flags[4] = 1'b1;
      end
      st_nxt.wake = |st_r.hit[2:0];
      // A flag latched before its enable dropped shows once enabled again
      st_nxt.irq = |(st_nxt.flags[3:0] & st_nxt.ien) | st_nxt.flags[4];
   end

   // State register with freeze
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_r <= RST_ST;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // ==================================
   // Outputs
   assign hreadyout = !st_r.rd_pend;
   assign hrdata = {16'h0000, st_r.rdata};
   assign hresp = 1'b0;
   assign wake_pulse = st_r.wake;
   assign irq = st_r.irq;

   // ==================================
   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n || !ce);

   AST_PERIODIC_RELOAD: assert property (
      st_r.run_eff && tk.tick && !free && m[2]
      |=> st_r.count == $past(start))
      else $error("periodic reload missed");

   AST_FREE_WRAP: assert property (
      st_r.run_eff && tk.tick && free && !dir && st_r.count == wkt_pkg::FULL_SCALE
      |=> st_r.count == 32'h00000000)
      else $error("free-run wrap wrong");

   AST_STEP: assert property (
      st_r.run_eff && tk.tick && !m[2] && dir
      |=> st_r.count == $past(st_r.count) - 32'h00000001)
      else $error("count step wrong");

   AST_NO_MATCH_OFF: assert property (
      tk.tick && !st_r.ien[0] |=> !st_r.hit[0] ##1 (!st_r.wake || $past(st_r.hit[1]) || $past(st_r.hit[2])))
      else $error("disabled field matched");

   AST_LATCH_IRQ: assert property (
      st_r.hit[2] ##1 st_r.ien[2] |-> st_r.irq && st_r.flags[2])
      else $error("latched match lost");

   AST_HALF_READ: assert property (
      st_r.rd_pend && st_r.addr == wkt_pkg::OFS_CNT_LO
      |=> hrdata == {16'h0000, $past(st_r.count[15:0])} && hreadyout)
      else $error("low half read wrong");

   AST_FREEZE: assert property (
      st_r.rd_pend && st_r.addr == wkt_pkg::OFS_CNT_LO && st_r.ctrl[wkt_pkg::CB_FRZ]
      |=> st_r.frozen && st_r.hold_hi == $past(st_r.count[31:16]))
      else $error("freeze not taken");

   AST_HELD: assert property (
      !st_r.run_eff |=> st_r.count == $past(start))
      else $error("stopped counter moved");

   AST_SYNC_SET: assert property (
      st_r.wr_pend && st_r.addr == wkt_pkg::OFS_RUN && wd[0] != st_r.run_en
      |=> st_r.en_sync && st_r.run_en == $past(wd[0]))
      else $error("sync flag not set");

   AST_SYNC_DONE: assert property (
      $fell(st_r.en_sync) |-> st_r.run_eff == st_r.run_en)
      else $error("sync ended early");

   AST_STAT_CLR: assert property (
      st_r.rd_pend && st_r.addr == wkt_pkg::OFS_STAT && !st_r.hit[0]
      |=> !st_r.flags[0])
      else $error("status read kept flag");

   AST_CAPTURE: assert property (
      cap_ev |=> st_r.flags[4] && st_r.cap == $past(st_r.count))
      else $error("capture missed");

   AST_CLR: assert property (
      st_r.wr_pend && st_r.addr == wkt_pkg::OFS_CLR && wd[2] && !st_r.hit[2]
      |=> !st_r.flags[2])
      else $error("clear ignored");
endmodule

// ### dv/tb_wakeup_timer_32bit.sv
`timescale 1ns/1ps
module tb_wakeup_timer_32bit;
   // ==========================
   // Stimulus and observed nets
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic slow_oscillator = 1'b0; // Paces run-bit sync
   logic [12:0] event_lines = 13'h0;
   logic hreadyout;
   logic hresp;
   logic wake_pulse;
   logic irq;
   logic [31:0] hrdata;
   logic [31:0] rdata; // Word of the last read
   int bad_count = 0;
   int checks = 0;
   // Small divider keeps the longest prescale short
   wkt_top #(.PRE_DIV_MAX(8)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .slow_oscillator(slow_oscillator), .user_clock(slow_oscillator), .external_tick_input(slow_oscillator),
      .event_lines(event_lines), .wake_pulse(wake_pulse), .irq(irq));
   // ==========================
   // Clocks: 50 ns ref; slow pin toggles every 7 ref edges and also feeds user and ext
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      forever begin
         repeat (7) @(posedge ref_clk);
         slow_oscillator <= ~slow_oscillator;
      end
   end
   // ==========================
   // Shared tasks
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One single AHB transfer; each phase waits for hready, the watchdog ends hangs
   task automatic bus(input logic w, input logic [6:0] a, input logic [15:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {25'h0, a};
      hwrite <= w;
      do begin
         @(posedge ref_clk);
      end while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {16'h0, d};
      do begin
         @(posedge ref_clk);
      end while (hreadyout !== 1'b1);
      rdata = hrdata;
   endtask
   task automatic rd(input logic [6:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 16'h0);
      chk(what, rdata, exp);
   endtask
   // Run bit change, then poll until the sync flag drops
   task automatic set_run(input logic v);
      int n;
      bus(1'b1, wkt_pkg::OFS_RUN, {15'h0, v});
      n = 0;
      do begin
         bus(1'b0, wkt_pkg::OFS_STAT, 16'h0);
         n++;
      end while (rdata[8] !== 1'b0 && n < 100);
      chk("sync flag", rdata & 32'h100, 32'h0);
   endtask
   // Safe reconfiguration order: stop, synced, write, start
   task automatic cfg(input logic [15:0] c);
      set_run(1'b0);
      bus(1'b1, wkt_pkg::OFS_CTRL, c);
      set_run(1'b1);
   endtask
   // Cycles until the next wake pulse, bounded
   task automatic wait_wake(output int n);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wake_pulse !== 1'b1 && n < 2000);
      chk("wake seen", {31'h0, wake_pulse}, 32'h1);
   endtask
   // ==========================
   // Scenarios
   task automatic t_reset;
      logic [6:0] ofs [15] = '{7'h00, 7'h04, 7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h1C, 7'h20, 7'h24,
         7'h28, 7'h2C, 7'h3C, 7'h40, 7'h34};
      logic [15:0] exp [15] = '{16'h0, 16'h0, 16'h0010, 16'h0, 16'h1FFF, 16'h0, 16'h2FFF, 16'h0,
         16'h3FFF, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
      foreach (ofs[i]) rd(ofs[i], {16'h0, exp[i]}, "reset value");
      bus(1'b1, 7'h34, 16'hFFFF);
      rd(7'h34, 32'h0, "unmapped");
      chk("response", {31'h0, hresp}, 32'h0);
      bus(1'b1, wkt_pkg::OFS_CNT_LO, 16'hAAAA);
      rd(wkt_pkg::OFS_CNT_LO, 32'h0, "count read only");
      bus(1'b1, wkt_pkg::OFS_CTRL, 16'hFFFF);
      rd(wkt_pkg::OFS_CTRL, 32'h0FFF, "control");
      bus(1'b1, wkt_pkg::OFS_IEN, 16'hFFFF);
      rd(wkt_pkg::OFS_IEN, 32'hF, "enable mask");
      bus(1'b1, wkt_pkg::OFS_IEN, 16'h0);
      bus(1'b1, wkt_pkg::OFS_CMPA_LO, 16'h1234);
      rd(wkt_pkg::OFS_CMPA_LO, 32'h1234, "field a");
      bus(1'b1, wkt_pkg::OFS_CTRL, 16'h0010);
      $display("test reset done");
   endtask
   task automatic t_run;
      logic [15:0] first;
      bus(1'b1, wkt_pkg::OFS_RUN, 16'h1);
      bus(1'b0, wkt_pkg::OFS_STAT, 16'h0);
      chk("sync set", rdata & 32'h100, 32'h100);
      set_run(1'b1);
      bus(1'b0, wkt_pkg::OFS_CNT_LO, 16'h0);
      first = rdata[15:0];
      // Ticks come every fourth cycle, so let one pass for sure
      repeat (4) @(posedge ref_clk);
      bus(1'b0, wkt_pkg::OFS_CNT_LO, 16'h0);
      chk("count moves", {31'h0, rdata[15:0] > first}, 32'h1);
      rd(wkt_pkg::OFS_CNT_HI, 32'h0, "count high");
      set_run(1'b0);
      rd(wkt_pkg::OFS_CNT_LO, 32'h0, "stopped up");
      cfg(16'h0014);
      rd(wkt_pkg::OFS_CNT_HI, 32'hFFFF, "down high");
      set_run(1'b0);
      rd(wkt_pkg::OFS_CNT_LO, 32'hFFFF, "stopped down");
      $display("test run done");
   endtask
   // Field C = 1 gives two ticks per period; pin sources rise every 14 cycles
   task automatic t_prescale;
      int n;
      int div [7] = '{4, 16, 256, 8, 14, 56, 14};
      bus(1'b1, wkt_pkg::OFS_CMPC_LO, 16'h1);
      bus(1'b1, wkt_pkg::OFS_IEN, 16'h4);
      for (int k = 0; k < 7; k++) begin
         cfg((k < 4) ? {14'h0, k[1:0]} : {9'h0, k[1:0] + 2'h1, 5'h0});
         wait_wake(n);
         wait_wake(n);
         chk("period", n, 2 * div[k]);
      end
      $display("test prescale done");
   endtask
   task automatic t_match;
      int n;
      set_run(1'b0);
      bus(1'b1, wkt_pkg::OFS_CMPC_LO, 16'h5);
      bus(1'b1, wkt_pkg::OFS_CMPA_LO, 16'h2);
      cfg(16'h0000);
      wait_wake(n);
      chk("irq on match", {31'h0, irq}, 32'h1);
      bus(1'b1, wkt_pkg::OFS_CLR, 16'h4);
      repeat (2) @(posedge ref_clk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      wait_wake(n);
      bus(1'b0, wkt_pkg::OFS_STAT, 16'h0);
      chk("flags", rdata & 32'hF, 32'h4);
      bus(1'b0, wkt_pkg::OFS_STAT, 16'h0);
      chk("flags read clear", rdata & 32'h7, 32'h0);
      bus(1'b0, wkt_pkg::OFS_CNT_LO, 16'h0);
      chk("reload", {31'h0, rdata <= 32'h5}, 32'h1);
      // Flag latched, enable dropped then restored: the line follows
      wait_wake(n);
      bus(1'b1, wkt_pkg::OFS_RUN, 16'h0);
      bus(1'b1, wkt_pkg::OFS_IEN, 16'h0);
      @(posedge ref_clk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      bus(1'b1, wkt_pkg::OFS_IEN, 16'h4);
      @(posedge ref_clk);
      chk("latched irq", {31'h0, irq}, 32'h1);
      $display("test match done");
   endtask
   // Free run: a reached field is moved on with its enable off meanwhile
   task automatic t_free;
      int n;
      bus(1'b1, wkt_pkg::OFS_IEN, 16'h1);
      cfg(16'h0010);
      wait_wake(n);
      bus(1'b1, wkt_pkg::OFS_IEN, 16'h0);
      bus(1'b1, wkt_pkg::OFS_CMPA_LO, 16'h8);
      bus(1'b1, wkt_pkg::OFS_IEN, 16'h1);
      wait_wake(n);
      bus(1'b0, wkt_pkg::OFS_STAT, 16'h0);
      chk("free match", rdata & 32'hF, 32'h1);
      $display("test free done");
   endtask
   task automatic t_freeze;
      bus(1'b1, wkt_pkg::OFS_IEN, 16'h0);
      cfg(16'h0018);
      bus(1'b0, wkt_pkg::OFS_CNT_LO, 16'h0);
      bus(1'b0, wkt_pkg::OFS_STAT, 16'h0);
      chk("frozen", rdata & 32'h80, 32'h80);
      rd(wkt_pkg::OFS_CNT_HI, 32'h0, "frozen high");
      bus(1'b0, wkt_pkg::OFS_STAT, 16'h0);
      chk("unfrozen", rdata & 32'h80, 32'h0);
      $display("test freeze done");
   endtask
   // Every source code, reserved code 13 and a disabled pass
   task automatic t_capture;
      logic [3:0] code;
      logic on;
      logic [31:0] cap;
      for (int k = 0; k < 15; k++) begin
         code = (k == 14) ? 4'h3 : k[3:0];
         on = (k < 13);
         cfg({4'h0, code, k != 14, 7'h10});
         event_lines <= (k < 13) ? (13'h1 << k) : 13'h1FFF;
         repeat (6) @(posedge ref_clk);
         event_lines <= 13'h0;
         repeat (6) @(posedge ref_clk);
         chk("capture irq", {31'h0, irq}, {31'h0, on});
         bus(1'b0, wkt_pkg::OFS_STAT, 16'h0);
         chk("capture flag", rdata & 32'h10, on ? 32'h10 : 32'h0);
         bus(1'b0, wkt_pkg::OFS_CAP_LO, 16'h0);
         cap = rdata;
         bus(1'b0, wkt_pkg::OFS_CNT_LO, 16'h0);
         chk("capture count", {31'h0, cap <= rdata}, 32'h1);
         rd(wkt_pkg::OFS_CAP_HI, 32'h0, "capture high");
      end
      $display("test capture done");
   endtask
   // ==========================
   // Main sequence and watchdog
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_reset;
      t_run;
      t_prescale;
      t_match;
      t_free;
      t_freeze;
      t_capture;
      tally_and_finish;
   end
   initial begin
      #(50 * 40000);
      bad_count++;
      $display("watchdog expired");
      tally_and_finish;
   end
endmodule
